// ### tdm_frame_port_defines.vh
// Notes on behaviour
// - Receive register: channel 1 in high byte, channel 0 in low byte, reset zero.
// - Transmit register: channel 1 in high byte, channel 0 in low byte, reset zero.
// - Control word selects rate, active slots and slot-to-buffer mapping; resets to zero.
// - Mode codes 000 and 001 leave the port inactive; no bus activity at all.
// - Codes 010/011/101/111: slave, doubled clock, 4/8/16/32 slots per frame.
// - Code 100: 768 kbit/s, 12 slots, master or slave.
// - Code 110: slave, 32 slots, bit clock equals the data rate.
// - Each buffer has slot field and active flag; exchanged only in its slot.
// - Frame sync rising edge marks first bit of slot 0; slots are eight bits.
// - Outside speech mode each data bit spans two bit-clock periods.
// - Sixteen-bit samples occupy two consecutive slots for the channel.
// - Slave takes frame sync and bit clock in; master drives both out.
`ifndef TDM_FRAME_PORT_DEFINES_VH
`define TDM_FRAME_PORT_DEFINES_VH

// Register byte offsets
`define REG_RX_BUFFERS      8'h00
`define REG_TX_BUFFERS      8'h04
`define REG_PORT_CONTROL    8'h08
`define REG_PORT_CONFIG     8'h0c
`define REG_PORT_STATUS     8'h10

// Reset values
`define RST_RX_BUFFERS      16'h0000
`define RST_TX_BUFFERS      16'h0000
`define RST_PORT_CONTROL    16'h0000

// Control word fields
`define CTL_MODE_HI         15
`define CTL_MODE_LO         13
`define CTL_SLOT0_HI        12
`define CTL_SLOT0_LO        8
`define CTL_ACT0_BIT        6
`define CTL_ACT1_BIT        5
`define CTL_SLOT1_HI        4
`define CTL_SLOT1_LO        0

// Mode codes
`define MODE_256            3'h2
`define MODE_512            3'h3
`define MODE_768            3'h4
`define MODE_1024           3'h5
`define MODE_SPEECH         3'h6
`define MODE_2048           3'h7

// Config and status bits
`define CFG_MASTER_BIT      0
`define CFG_WORD_BIT        1
`define STS_RX_FULL_BIT     0
`define STS_OVERRUN_BIT     1

// Timing
`define BITS_PER_SLOT       8
`define HCLK_HZ             40000000
`define MASTER_BCLK_HZ      1536000
`define MASTER_HALF_CYC     (`HCLK_HZ / (2 * `MASTER_BCLK_HZ))
`define MASTER_BCLK_FRAME   192

`endif

// ### tdm_frame_port_control.v
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tdm_frame_port_defines.vh"

module tdm_word_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             hclk,
    input  wire             hresetn,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0]      level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_q];
    assign level     = cnt_q;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge hclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

module tdm_frame_port_control #(
    parameter FIFO_DEPTH  = 16,
    parameter FIFO_AW     = 4,
    parameter MASTER_HALF = `MASTER_HALF_CYC
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Frame bus
    input  wire        serial_in,
    output wire        serial_out_o,
    output wire        serial_out_oe,
    input  wire        frame_sync_i,
    output wire        frame_sync_o,
    output wire        frame_sync_oe,
    input  wire        bit_clock_i,
    output wire        bit_clock_o,
    output wire        bit_clock_oe
);
    ////////////////////////////////////////////////////////////////////////////
    // Slot lookup: {hit, byte index} for a slot number under a control word
    function [1:0] slot_map;
        input [5:0]  slot;
        input [15:0] ctl;
        input        word;
        reg   [5:0]  nslots;
        reg   [5:0]  s0;
        reg   [5:0]  s1;
        begin
            case (ctl[`CTL_MODE_HI:`CTL_MODE_LO])
                `MODE_256:  nslots = 6'h04;
                `MODE_512:  nslots = 6'h08;
                `MODE_768:  nslots = 6'h0c;
                `MODE_1024: nslots = 6'h10;
                `MODE_SPEECH, `MODE_2048: nslots = 6'h20;
                default:    nslots = 6'h00;
            endcase
            s0 = {1'b0, ctl[`CTL_SLOT0_HI:`CTL_SLOT0_LO]};
            s1 = {1'b0, ctl[`CTL_SLOT1_HI:`CTL_SLOT1_LO]};
            slot_map = 2'b00;
            if (slot < nslots) begin
                if (word) begin
                    // Sample spans slot0 and the next slot, high byte first
                    if (ctl[`CTL_ACT0_BIT] && slot == s0) begin
                        slot_map = 2'b11;
                    end else if (ctl[`CTL_ACT0_BIT] && slot == s0 + 6'h01) begin
                        slot_map = 2'b10;
                    end
                end else if (ctl[`CTL_ACT0_BIT] && slot == s0) begin
                    slot_map = 2'b10;
                end else if (ctl[`CTL_ACT1_BIT] && slot == s1) begin
                    slot_map = 2'b11;
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [15:0] rx_q;
    reg         rx_full_q;
    reg  [15:0] tx_q;
    reg  [15:0] ctl_q;
    reg  [1:0]  cfg_q;
    reg         overrun_q;
    reg         dp_act_q;
    reg         dp_wr_q;
    reg  [7:0]  dp_addr_q;

    wire [2:0]  mode    = ctl_q[`CTL_MODE_HI:`CTL_MODE_LO];
    wire        port_on = mode[2] | mode[1];
    wire        doubled = (mode != `MODE_SPEECH);
    wire        master  = port_on & cfg_q[`CFG_MASTER_BIT] & (mode == `MODE_768);
    wire        word    = cfg_q[`CFG_WORD_BIT];

    wire        ap_take = hsel & htrans[1] & hready;
    wire        wr_tx   = dp_act_q & dp_wr_q & (dp_addr_q == `REG_TX_BUFFERS);
    wire        wr_ctl  = dp_act_q & dp_wr_q & (dp_addr_q == `REG_PORT_CONTROL);
    wire        wr_cfg  = dp_act_q & dp_wr_q & (dp_addr_q == `REG_PORT_CONFIG);
    wire        wr_sts  = dp_act_q & dp_wr_q & (dp_addr_q == `REG_PORT_STATUS);
    wire        rd_rx   = dp_act_q & ~dp_wr_q & (dp_addr_q == `REG_RX_BUFFERS);

    // Zero wait states; every transfer completes OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, third stage only for edge detection
    reg  [2:0] bclk_s;
    reg  [2:0] fs_s;
    reg  [1:0] din_s;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bclk_s <= 3'h0;
            fs_s   <= 3'h0;
            din_s  <= 2'h0;
        end else begin
            bclk_s <= {bclk_s[1:0], bit_clock_i};
            fs_s   <= {fs_s[1:0], frame_sync_i};
            din_s  <= {din_s[0], serial_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master clock and frame generator
    reg  [7:0] hcnt_q;
    reg        gclk_q;
    reg  [7:0] gcnt_q;
    reg        gfs_q;
    wire       gtick     = master & (hcnt_q == MASTER_HALF[7:0] - 8'h01);
    wire       gen_rise  = gtick & ~gclk_q;
    wire       gen_fall  = gtick & gclk_q;
    wire       gfs_last  = (gcnt_q == `MASTER_BCLK_FRAME - 1);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hcnt_q <= 8'h00;
            gclk_q <= 1'b0;
            gcnt_q <= 8'h00;
            gfs_q  <= 1'b0;
        end else if (!master) begin
            hcnt_q <= 8'h00;
            gclk_q <= 1'b0;
            gcnt_q <= 8'h00;
            gfs_q  <= 1'b0;
        end else begin
            hcnt_q <= gtick ? 8'h00 : hcnt_q + 8'h01;
            if (gtick) begin
                gclk_q <= ~gclk_q;
            end
            if (gen_rise) begin
                gcnt_q <= gfs_last ? 8'h00 : gcnt_q + 8'h01;
            end
            // Sync rises half a bit clock ahead of the frame's first rising edge
            if (gen_fall) begin
                gfs_q <= gfs_last;
            end
        end
    end

    assign bit_clock_o   = gclk_q;
    assign frame_sync_o  = gfs_q;
    assign bit_clock_oe  = master;
    assign frame_sync_oe = master;

    ////////////////////////////////////////////////////////////////////////////
    // Frame timing
    wire clk_rise = master ? gen_rise : (bclk_s[1] & ~bclk_s[2]);
    wire clk_fall = master ? gen_fall : (~bclk_s[1] & bclk_s[2]);
    wire fs_rise  = master ? (gen_fall & gfs_last & ~gfs_q) : (fs_s[1] & ~fs_s[2]);

    reg         pend_q;
    reg         run_q;
    reg  [8:0]  pos_q;
    reg         sub_q;
    reg  [15:0] txs_q;
    reg  [15:0] rxs_q;
    reg         oe_q;
    reg  [8:0]  pos_d;
    reg         sub_d;
    wire [1:0]  map_d = slot_map(pos_d[8:3], ctl_q, word);
    wire [1:0]  map_q = slot_map(pos_q[8:3], ctl_q, word);
    wire [3:0]  tx_idx = {map_d[0], ~pos_d[2:0]};
    wire [3:0]  rx_idx = {map_q[0], ~pos_q[2:0]};

    // Each data bit takes two bit-clock periods except in speech mode
    always @* begin
        pos_d = pos_q;
        sub_d = sub_q;
        if (pend_q) begin
            pos_d = 9'h000;
            sub_d = 1'b0;
        end else if (doubled && !sub_q) begin
            sub_d = 1'b1;
        end else begin
            sub_d = 1'b0;
            pos_d = pos_q[8] ? pos_q : pos_q + 9'h001;
        end
    end

    // FIFO fill side
    wire        push_req = fs_rise & run_q & port_on &
                           (ctl_q[`CTL_ACT0_BIT] | ctl_q[`CTL_ACT1_BIT]);
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire [FIFO_AW:0] fifo_level;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 1'b0;
            run_q  <= 1'b0;
            pos_q  <= 9'h000;
            sub_q  <= 1'b0;
            txs_q  <= 16'h0000;
            rxs_q  <= 16'h0000;
            oe_q   <= 1'b0;
        end else if (!port_on) begin
            pend_q <= 1'b0;
            run_q  <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            if (fs_rise) begin
                pend_q <= 1'b1;
                run_q  <= 1'b0;
                oe_q   <= 1'b0;
                txs_q  <= tx_q;
            end else if (clk_rise && (pend_q || run_q)) begin
                pend_q <= 1'b0;
                run_q  <= 1'b1;
                pos_q  <= pos_d;
                sub_q  <= sub_d;
                // Open drain: pull low for a zero, release for a one or idle slot
                if (!sub_d) begin
                    oe_q <= map_d[1] & ~txs_q[tx_idx];
                end
            end
            // Sample late in the bit, on the falling edge of its last period
            if (clk_fall && run_q && !pend_q && (sub_q || !doubled) && map_q[1]) begin
                rxs_q[rx_idx] <= din_s[1];
            end
        end
    end

    assign serial_out_o  = 1'b0;
    assign serial_out_oe = oe_q;

    // Full buffer drops the frame and flags overrun
    tdm_word_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_rx_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (push_req),
        .in_ready  (fifo_in_ready),
        .in_data   (rxs_q),
        .out_valid (fifo_out_valid),
        .out_ready (~rx_full_q),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    wire rx_load = fifo_out_valid & ~rx_full_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_q      <= `RST_RX_BUFFERS;
            rx_full_q <= 1'b0;
            tx_q      <= `RST_TX_BUFFERS;
            ctl_q     <= `RST_PORT_CONTROL;
            cfg_q     <= 2'b00;
            overrun_q <= 1'b0;
            dp_act_q  <= 1'b0;
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 8'h00;
        end else begin
            dp_act_q <= ap_take;
            if (ap_take) begin
                dp_wr_q   <= hwrite;
                dp_addr_q <= haddr;
            end
            if (rx_load) begin
                rx_q <= fifo_out_data;
            end
            rx_full_q <= rx_load | (rx_full_q & ~rd_rx);
            if (wr_tx) begin
                tx_q <= hwdata[15:0];
            end
            if (wr_ctl) begin
                ctl_q <= hwdata[15:0];
            end
            if (wr_cfg) begin
                cfg_q <= hwdata[1:0];
            end
            // New overrun wins over a simultaneous clear
            overrun_q <= (push_req & ~fifo_in_ready) |
                         (overrun_q & ~(wr_sts & hwdata[`STS_OVERRUN_BIT]));
        end
    end

    always @* begin
        hrdata = 32'h00000000;
        if (dp_act_q && !dp_wr_q) begin
            case (dp_addr_q)
                `REG_RX_BUFFERS:   hrdata = {16'h0000, rx_q};
                `REG_TX_BUFFERS:   hrdata = {16'h0000, tx_q};
                `REG_PORT_CONTROL: hrdata = {16'h0000, ctl_q};
                `REG_PORT_CONFIG:  hrdata = {30'h00000000, cfg_q};
                `REG_PORT_STATUS:  hrdata = {{(23-FIFO_AW){1'b0}}, fifo_level, 4'h0,
                                             run_q, master, overrun_q, rx_full_q};
                default:           hrdata = 32'h00000000;
            endcase
        end
    end
endmodule

// ### tdm_port_props.sv
`timescale 1ns/1ps
`include "tdm_frame_port_defines.vh"

module tdm_port_props (
    // Clock and reset
    input wire        hclk,
    input wire        hresetn,
    // Register bus
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    // Frame bus
    input wire        serial_out_o,
    input wire        serial_out_oe,
    input wire        frame_sync_oe,
    input wire        bit_clock_oe
);
    reg        ph_q;
    reg        wr_q;
    reg [7:0]  adr_q;
    reg [15:0] ctl_q;
    wire       rdph = ph_q && !wr_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Shadow of the control word, so pin behaviour can be tied to what software wrote
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q  <= 1'b0;
            wr_q  <= 1'b0;
            adr_q <= 8'h00;
            ctl_q <= 16'h0000;
        end else begin
            ph_q  <= hsel && htrans[1] && hready;
            wr_q  <= hwrite;
            adr_q <= haddr;
            if (ph_q && wr_q && adr_q == `REG_PORT_CONTROL)
                ctl_q <= hwdata[15:0];
        end
    end

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_rd_idle: assert property (!rdph |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    a_rd_upper: assert property (rdph |-> hrdata[31:16] == 16'h0)
        else $error("upper read data bits not zero");
    a_ctl_back: assert property (rdph && adr_q == `REG_PORT_CONTROL |-> hrdata[15:0] == ctl_q)
        else $error("control word read back differs");
    a_rd_unmap: assert property (rdph && adr_q > `REG_PORT_STATUS |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_idle_quiet: assert property ((ctl_q[15:14] == 2'b00) [*4] |->
        !(serial_out_oe || frame_sync_oe || bit_clock_oe))
        else $error("pins driven while port inactive");
    a_pins_pair: assert property (frame_sync_oe == bit_clock_oe)
        else $error("frame sync and bit clock drive differ");
    a_master_mode: assert property (frame_sync_oe |->
        ctl_q[15:13] == `MODE_768 || $past(ctl_q[15:13]) == `MODE_768)
        else $error("master drive outside the 768 mode");
    a_drain_low: assert property (serial_out_oe |-> !serial_out_o && $past(|ctl_q[15:14]))
        else $error("data line pulled while port inactive");

    c_master: cover property (frame_sync_oe);
    c_ctl_read: cover property (rdph && adr_q == `REG_PORT_CONTROL);
    c_data_out: cover property (serial_out_oe);
endmodule

bind tdm_frame_port_control tdm_port_props props_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .serial_out_o(serial_out_o),
    .serial_out_oe(serial_out_oe), .frame_sync_oe(frame_sync_oe),
    .bit_clock_oe(bit_clock_oe)
);

// ### tdm_bus_model.sv
`timescale 1ns/1ps

module tdm_bus_model (
    // Data line, pulled up
    input  wire  serial_out_oe,
    output wire  serial_in,
    // Frame timing from the far side
    output logic frame_sync_i,
    output logic bit_clock_i
);
    logic       drv_q = 1'b1;
    logic [7:0] recv [0:31];

    // Wired-and: low while either party pulls it
    assign serial_in = drv_q & ~serial_out_oe;

    initial begin
        frame_sync_i = 1'b0;
        bit_clock_i  = 1'b0;
    end

    function automatic logic [7:0] pat(input int s);
        return {s[4:0], 3'b101};
    endfunction

    // Clock stands still between frames; the 13 ns lead keeps edges off hclk
    task automatic frame(input int nslots, input int per);
        logic [7:0] bt;
        #13;
        frame_sync_i = 1'b1;
        #100;
        for (int s = 0; s < nslots; s++) begin
            bt = pat(s);
            for (int b = 7; b >= 0; b--) begin
                for (int p = 0; p < per; p++) begin
                    bit_clock_i = 1'b1;
                    if (p == 0) drv_q = bt[b];
                    #100;
                    bit_clock_i  = 1'b0;
                    frame_sync_i = 1'b0;
                    if (p == per - 1) recv[s][b] = serial_in;
                    #100;
                end
            end
        end
        drv_q        = 1'b1;
        frame_sync_i = 1'b0;
        #200;
    endtask
endmodule

// ### tdm_frame_port_control_tb.sv
`timescale 1ns/1ps
`include "tdm_frame_port_defines.vh"

module tdm_frame_port_control_tb;
    localparam logic [15:0] TXV = 16'h5ac3;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [7:0]  haddr   = 8'h00;
    logic [1:0]  htrans  = 2'b00;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    wire         hreadyout;
    wire         hresp;
    wire [31:0]  hrdata;
    wire         serial_in;
    wire         serial_out_oe;
    wire         frame_sync_i;
    wire         frame_sync_oe;
    wire         bit_clock_i;
    wire         bit_clock_oe;
    wire         frame_sync_o;
    wire         bit_clock_o;
    int          fails     = 0;
    int          cmp_count = 0;
    logic [31:0] rv;
    int          cyc       = 0;
    int          ck_n      = 0;
    int          fs_n      = 0;
    logic        fs_d      = 1'b1;
    logic        ck_d      = 1'b1;

    always #12.5 hclk = ~hclk;

    tdm_frame_port_control dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_in(serial_in),
        .serial_out_o(), .serial_out_oe(serial_out_oe), .frame_sync_i(frame_sync_i),
        .frame_sync_o(frame_sync_o), .frame_sync_oe(frame_sync_oe), .bit_clock_i(bit_clock_i),
        .bit_clock_o(bit_clock_o), .bit_clock_oe(bit_clock_oe)
    );

    tdm_bus_model model_u (
        .serial_out_oe(serial_out_oe), .serial_in(serial_in),
        .frame_sync_i(frame_sync_i), .bit_clock_i(bit_clock_i)
    );

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Single transfer; the slave's hreadyout ends each phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        rv = hrdata;
    endtask

    task automatic xchg(input logic [2:0] m, input logic [4:0] s0, input logic [4:0] s1,
                        input logic wd);
        logic [7:0]  eb [0:31];
        logic [15:0] ctl;
        int          n;
        logic [31:0] exp_rx;
        n   = (m >= `MODE_SPEECH) ? 32 : 4 * (m - 1);
        ctl = {m, s0, 2'b01, !wd, s1};
        for (int s = 0; s < 32; s++) eb[s] = model_u.pat(s);
        if (wd) begin
            eb[s0]     &= TXV[15:8];
            eb[s0 + 1] &= TXV[7:0];
        end else begin
            eb[s0] &= TXV[7:0];
            eb[s1] &= TXV[15:8];
        end
        xfer(1'b1, `REG_PORT_CONFIG, {30'h0, wd, 1'b0});
        xfer(1'b1, `REG_PORT_CONTROL, {16'h0, ctl});
        xfer(1'b0, `REG_PORT_CONTROL, 32'h0);
        chk("control", {16'h0, ctl}, rv);
        repeat (2) model_u.frame(n, (m == `MODE_SPEECH) ? 1 : 2);
        model_u.frame(0, 2);
        for (int s = 0; s < n; s++) begin
            chk("bus slot", {24'h0, eb[s]}, {24'h0, model_u.recv[s]});
        end
        exp_rx = wd ? {16'h0, eb[s0], eb[s0 + 1]} : {16'h0, eb[s1], eb[s0]};
        repeat (2) begin
            xfer(1'b0, `REG_RX_BUFFERS, 32'h0);
            chk("rx word", exp_rx, rv);
            repeat (3) @(posedge hclk);
        end
    endtask

    initial begin
        #1_500_000;
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", 32'h0, rv);
        end
        xfer(1'b1, `REG_TX_BUFFERS, {16'hffff, TXV});
        xfer(1'b0, `REG_TX_BUFFERS, 32'h0);
        chk("tx buffers", {16'h0, TXV}, rv);
        xfer(1'b1, `REG_RX_BUFFERS, 32'h1234);
        xfer(1'b0, `REG_RX_BUFFERS, 32'h0);
        chk("rx read only", 32'h0, rv);
        xfer(1'b1, 8'h40, 32'hffff);
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rv);
        // Master drive only in the 768 mode with the master bit set
        xfer(1'b1, `REG_PORT_CONFIG, 32'h1);
        xfer(1'b1, `REG_PORT_CONTROL, 32'h8000);
        repeat (4) @(posedge hclk);
        chk("master pins", 32'h3, {30'h0, frame_sync_oe, bit_clock_oe});
        // Time one generated frame from sync rise to sync rise
        while (fs_n < 2) begin
            @(posedge hclk);
            if (fs_n == 1) begin
                cyc++;
                ck_n += (bit_clock_o && !ck_d) ? 1 : 0;
            end
            if (frame_sync_o && !fs_d) begin
                fs_n++;
            end
            fs_d = frame_sync_o;
            ck_d = bit_clock_o;
        end
        chk("master frame", 2 * `MASTER_HALF_CYC * `MASTER_BCLK_FRAME, cyc);
        chk("master bit clocks", `MASTER_BCLK_FRAME, ck_n);
        xfer(1'b1, `REG_PORT_CONFIG, 32'h0);
        repeat (4) @(posedge hclk);
        chk("slave pins", 32'h0, {30'h0, frame_sync_oe, bit_clock_oe});
        // Park the port so the generated frames leave nothing to push later
        xfer(1'b1, `REG_PORT_CONTROL, 32'h0);
        xchg(`MODE_256, 5'd3, 5'd0, 1'b0);
        xchg(`MODE_512, 5'd7, 5'd2, 1'b0);
        xchg(`MODE_768, 5'd11, 5'd5, 1'b0);
        xchg(`MODE_1024, 5'd15, 5'd1, 1'b0);
        xchg(`MODE_SPEECH, 5'd31, 5'd0, 1'b0);
        xchg(`MODE_2048, 5'd30, 5'd31, 1'b0);
        xchg(`MODE_256, 5'd1, 5'd0, 1'b1);
        xfer(1'b1, `REG_PORT_CONTROL, 32'h2061);
        model_u.frame(4, 2);
        model_u.frame(0, 2);
        for (int s = 0; s < 4; s++) begin
            chk("idle slot", {24'h0, model_u.pat(s)}, {24'h0, model_u.recv[s]});
        end
        xfer(1'b0, `REG_PORT_STATUS, 32'h0);
        chk("rx full", 32'h0, rv & 32'h1);
        report_and_stop();
    end
endmodule
